/* pcim_checker.sv */
// Pin-level assertions for the bus master controller.
`timescale 1ns/1ps
module pcim_checker
(
	// Watched ports.
	input wire        clock_i, sys_rst_i, req_ready_o, rsp_valid_o, ad_oe_o, cbe_oe_o, par_out_o, par_oe_o,
	input wire        frame_n_out_o, frame_n_oe_o, irdy_n_out_o, irdy_n_oe_o, serr_n_out_o, serr_n_oe_o,
	input wire        frame_n_i, irdy_n_i, perr_n_out_o, perr_n_oe_o,
	input wire [3:0]  req_cmd_i, req_be_n_i, cbe_n_out_o,
	input wire [31:0] req_addr_i, req_wdata_i, ad_out_o
);
	// All checks share the bus clock and sleep during reset.
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	a_addr_phase: assert property (
		req_ready_o |-> !frame_n_out_o && frame_n_oe_o && cbe_oe_o && ad_oe_o && cbe_n_out_o == $past(req_cmd_i)
		&& ad_out_o == ($past(req_cmd_i[3:1]) == 3'h1 ? $past(req_addr_i) : $past(req_addr_i) & 32'hfffffffc))
		else $error("bad address phase");
	a_addr_parity: assert property (
		req_ready_o |=> par_oe_o && par_out_o == ^$past({ad_out_o, cbe_n_out_o})) else $error("bad address parity");
	a_byte_enables: assert property (
		req_ready_o |=> !irdy_n_out_o && cbe_n_out_o == $past(req_be_n_i, 2)) else $error("bad byte enables");
	a_write_data: assert property (
		req_ready_o && $past(req_cmd_i[0]) |=> ad_oe_o && ad_out_o == $past(req_wdata_i, 2)) else $error("bad write data");
	a_data_parity: assert property (
		ad_oe_o && !irdy_n_out_o && irdy_n_oe_o |=> par_oe_o && par_out_o == ^$past({ad_out_o, cbe_n_out_o}))
		else $error("bad write parity");
	a_read_par_off: assert property (
		!ad_oe_o && !irdy_n_out_o && irdy_n_oe_o |=> !par_oe_o) else $error("parity driven in read");
	a_done_release: assert property (
		rsp_valid_o |-> irdy_n_out_o && !ad_oe_o && !cbe_oe_o ##1 !irdy_n_oe_o && !par_oe_o) else $error("bad release");
	a_frame_park: assert property (
		$fell(frame_n_oe_o) |-> $past(frame_n_out_o)) else $error("frame floated low");
	a_irdy_park: assert property (
		$fell(irdy_n_oe_o) |-> $past(irdy_n_out_o)) else $error("ready floated low");
	a_take_idle: assert property (
		$rose(frame_n_oe_o) |-> $past(frame_n_i) && $past(irdy_n_i)) else $error("bus taken while owned");
	a_serr_drain: assert property (
		!(serr_n_oe_o && serr_n_out_o)) else $error("error line driven high");
	a_perr_park: assert property (
		$fell(perr_n_oe_o) |-> $past(perr_n_out_o)) else $error("parity error line floated low");
endmodule // pcim_checker

bind pcim_master pcim_checker i_pcim_checker (.*);

/* pcim_consts.vh */
// Constants for the bus master controller: commands, widths and parity timing.
`ifndef PCIM_CONSTS_VH
`define PCIM_CONSTS_VH
`define PCIM_AD_W        32
`define PCIM_CBE_W       4
`define PCIM_CMD_IO_RD   4'h2
`define PCIM_CMD_IO_WR   4'h3
`define PCIM_CMD_MEM_RD  4'h6
`define PCIM_CMD_MEM_WR  4'h7
`define PCIM_CMD_CFG_RD  4'ha
`define PCIM_CMD_CFG_WR  4'hb
`define PCIM_CMD_WR_BIT  0
`define PCIM_DW_MASK     32'hfffffffc
`define PCIM_PAR_LAG     1
`endif

/* pcim_master.v */
// Bus master controller that runs single data phase reads and writes on the shared bus.
//
// How it works
// - Drive each owned sustained line high one cycle before releasing it.
// - Assert a sustained line only a cycle after the previous owner released it.
// - Open-drain lines are only pulled low or released, never driven high.
// - Each transaction has one address phase then one data phase on AD.
// - I/O addresses are byte addresses; memory and configuration use doubleword addresses.
// - Command lines carry the bus command during the address phase.
// - Byte enables stay valid for the whole data phase.
// - Parity makes ones across AD, command lines and parity even.
// - Address parity is driven one clock after the address phase.
// - Data parity valid one clock after the ready of the data driver.
// - Parity held until one clock after the data phase completes.
// - Master drives parity for address and write phases; target for reads.
// - A data phase completes when both ready lines are sampled low together.
// - Frame asserted at start, deasserted during the final data phase.
`timescale 1ns/1ps
`include "pcim_consts.vh"
module pcim_master
#(
	parameter AD_W  = `PCIM_AD_W,
	parameter CBE_W = `PCIM_CBE_W
)
(
	// Clock and reset.
	input  wire             clock_i,
	input  wire             sys_rst_i,
	// User request port.
	input  wire             req_valid_i,
	input  wire [3:0]       req_cmd_i,
	input  wire [AD_W-1:0]  req_addr_i,
	input  wire [AD_W-1:0]  req_wdata_i,
	input  wire [CBE_W-1:0] req_be_n_i,
	output reg              req_ready_o,
	// User answer port.
	output reg              rsp_valid_o,
	output reg  [AD_W-1:0]  rsp_rdata_o,
	output reg              rsp_perr_o,
	// Address/data lines.
	input  wire [AD_W-1:0]  ad_in_i,
	output reg  [AD_W-1:0]  ad_out_o,
	output reg              ad_oe_o,
	// Command/byte-enable lines.
	output reg  [CBE_W-1:0] cbe_n_out_o,
	output reg              cbe_oe_o,
	// Parity line.
	input  wire             par_in_i,
	output reg              par_out_o,
	output reg              par_oe_o,
	// Frame and initiator ready, sustained lines owned by the master.
	output reg              frame_n_out_o,
	output reg              frame_n_oe_o,
	output reg              irdy_n_out_o,
	output reg              irdy_n_oe_o,
	// Target ready, sampled from the target.
	input  wire             trdy_n_i,
	// Parity error, sustained line driven low on a bad read.
	output reg              perr_n_out_o,
	output reg              perr_n_oe_o,
	// Shared open-drain error line, never driven high and never pulled low; always left released.
	output reg              serr_n_out_o,
	output reg              serr_n_oe_o,
	// Bus idle sense: frame and initiator ready as seen on the wires.
	input  wire             frame_n_i,
	input  wire             irdy_n_i
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_PARK = 3'h3;
	localparam ST_TURN = 3'h4;

	reg  [2:0]       state;
	reg  [2:0]       next_state;
	reg              is_write;
	reg  [AD_W-1:0]  wdata;
	reg  [CBE_W-1:0] be_n;
	reg              rd_check;
	reg  [AD_W-1:0]  rd_hold;
	reg  [CBE_W-1:0] rd_be_hold;
	reg              bus_free;
	wire [AD_W-1:0]  ad_s;
	wire             par_s;
	wire             trdy_s;
	wire             frame_s;
	wire             irdy_s;
	wire             drv_par;
	wire             rd_par;
	wire [AD_W-1:0]  addr_fmt;

	// Align the address as the command demands.
	// Only I/O commands keep the two low address bits; the others address whole words.
	function [AD_W-1:0] pcim_fmt_addr;
		input [3:0]      cmd;
		input [AD_W-1:0] addr;
		begin
			if (cmd == `PCIM_CMD_IO_RD || cmd == `PCIM_CMD_IO_WR)
				pcim_fmt_addr = addr;
			else
				pcim_fmt_addr = addr & `PCIM_DW_MASK;
		end
	endfunction

	// All bus inputs cross two flip-flops; this costs two cycles of turnaround latency.
	pcim_sync #(.W(AD_W + 4), .RST_VAL(1'b1)) u_sync
	(
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.d_i       ({ad_in_i, par_in_i, trdy_n_i, frame_n_i, irdy_n_i}),
		.q_o       ({ad_s, par_s, trdy_s, frame_s, irdy_s})
	);

	// Parity on what the master itself puts on the lines.
	// It is combinational on the registered lines; par_out_o registers it, so the pin is one clock behind them.
	pcim_parity u_par_tx
	(
		.ad_i  (ad_out_o),
		.cbe_i (cbe_n_out_o),
		.par_o (drv_par)
	);

	// Parity expected for captured read data.
	pcim_parity u_par_rx
	(
		.ad_i  (rd_hold),
		.cbe_i (rd_be_hold),
		.par_o (rd_par)
	);

	assign addr_fmt = pcim_fmt_addr(req_cmd_i, req_addr_i);

	// Next state: address, one data phase, park lines high, then release.
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (req_valid_i && bus_free)
					next_state = ST_ADDR;
			ST_ADDR:
				next_state = ST_DATA;
			ST_DATA:
				if (!trdy_s)
					next_state = ST_PARK;
			ST_PARK:
				next_state = ST_TURN;
			ST_TURN:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	// Bus is free only after frame and initiator ready were seen high and floated a cycle.
	// The pins are read through the synchroniser, so a release by another master is
	// noticed two cycles late; this only delays the take, it never shortens the gap.
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
			bus_free <= 1'b0;
		else
			bus_free <= frame_s && irdy_s && !frame_n_oe_o && !irdy_n_oe_o;
	end

	// Drives the address, command, parity, frame and initiator ready lines on the rising edge.
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			state         <= ST_IDLE;
			is_write      <= 1'b0;
			wdata         <= 32'h0;
			be_n          <= 4'hf;
			ad_out_o      <= 32'h0;
			ad_oe_o       <= 1'b0;
			cbe_n_out_o   <= 4'hf;
			cbe_oe_o      <= 1'b0;
			par_out_o     <= 1'b0;
			par_oe_o      <= 1'b0;
			frame_n_out_o <= 1'b1;
			frame_n_oe_o  <= 1'b0;
			irdy_n_out_o  <= 1'b1;
			irdy_n_oe_o   <= 1'b0;
			req_ready_o   <= 1'b0;
			rsp_valid_o   <= 1'b0;
			rsp_rdata_o   <= 32'h0;
		end
		else
		begin
			state       <= next_state;
			req_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			// Parity always follows the lines of the previous cycle.
			par_out_o   <= drv_par;
			case (state)
				ST_IDLE:
					if (req_valid_i && bus_free)
					begin
						// Address phase: frame low, command on the byte-enable lines.
						req_ready_o   <= 1'b1;
						is_write      <= req_cmd_i[`PCIM_CMD_WR_BIT];
						wdata         <= req_wdata_i;
						be_n          <= req_be_n_i;
						ad_out_o      <= addr_fmt;
						ad_oe_o       <= 1'b1;
						cbe_n_out_o   <= req_cmd_i;
						cbe_oe_o      <= 1'b1;
						frame_n_out_o <= 1'b0;
						frame_n_oe_o  <= 1'b1;
						irdy_n_out_o  <= 1'b1;
						irdy_n_oe_o   <= 1'b1;
					end
				ST_ADDR:
				begin
					// Single data phase, so frame rises as initiator ready falls.
					frame_n_out_o <= 1'b1;
					irdy_n_out_o  <= 1'b0;
					cbe_n_out_o   <= be_n;
					par_oe_o      <= 1'b1;
					ad_out_o      <= is_write ? wdata : 32'h0;
					ad_oe_o       <= is_write;
				end
				ST_DATA:
				begin
					// Write parity stays driven one clock past the completing phase.
					par_oe_o <= is_write;
					// Target ready is seen two cycles late, so initiator ready stays low for
					// two cycles after the target has finished; the target must ignore that.
					if (!trdy_s)
					begin
						irdy_n_out_o <= 1'b1;
						ad_oe_o      <= 1'b0;
						cbe_oe_o     <= 1'b0;
						rsp_valid_o  <= 1'b1;
						rsp_rdata_o  <= ad_s;
					end
				end
				ST_PARK:
				begin
					// Lines sat high at least one cycle; now float them.
					frame_n_oe_o <= 1'b0;
					irdy_n_oe_o  <= 1'b0;
					par_oe_o     <= 1'b0;
				end
				ST_TURN:
					par_oe_o <= 1'b0;
				default:
					par_oe_o <= 1'b0;
			endcase
		end
	end

	// Capture read data to check the target's parity a clock later.
	// Parity trails its data by one clock on the pins and through the same two flip-flops,
	// so the held word lines up with the parity bit seen on the next edge.
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			rd_check   <= 1'b0;
			rd_hold    <= 32'h0;
			rd_be_hold <= 4'hf;
		end
		else
		begin
			rd_check   <= (state == ST_DATA) && !trdy_s && !is_write;
			rd_hold    <= ad_s;
			rd_be_hold <= be_n;
		end
	end

	// Read parity error: pulse the parity error line low; the open-drain error line stays released.
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			rsp_perr_o   <= 1'b0;
			perr_n_out_o <= 1'b1;
			perr_n_oe_o  <= 1'b0;
			serr_n_out_o <= 1'b0;
			serr_n_oe_o  <= 1'b0;
		end
		else
		begin
			rsp_perr_o   <= rd_check && (rd_par != par_s);
			serr_n_out_o <= 1'b0;
			serr_n_oe_o  <= 1'b0;
			// The error line is parked high for one cycle before it floats, like frame and ready.
			if (rd_check && (rd_par != par_s))
			begin
				perr_n_out_o <= 1'b0;
				perr_n_oe_o  <= 1'b1;
			end
			else if (!perr_n_out_o)
				perr_n_out_o <= 1'b1;
			else
				perr_n_oe_o  <= 1'b0;
		end
	end
endmodule // pcim_master

/* pcim_parity.v */
// Even parity generator over the address/data and command/byte-enable lines.
`timescale 1ns/1ps
module pcim_parity
(
	// Lines covered by parity.
	input  wire [31:0] ad_i,
	input  wire [3:0]  cbe_i,
	// Parity bit that makes the total count of ones even.
	output wire        par_o
);
	// Xor of all covered bits gives the bit that evens out the count.
	assign par_o = ^{ad_i, cbe_i};
endmodule // pcim_parity

/* pcim_sync.v */
// Two flip-flop synchroniser for a bundle of bus input lines.
`timescale 1ns/1ps
module pcim_sync
#(
	parameter W = 1,
	parameter RST_VAL = 1'b1
)
(
	// Clock and reset.
	input  wire         clock_i,
	input  wire         sys_rst_i,
	// Raw and synchronised lines.
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta;

	// Only the second stage reads the first one.
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			meta <= {W{RST_VAL}};
			q_o  <= {W{RST_VAL}};
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule // pcim_sync

/* pcim_tgt_model.sv */
// Behavioural bus target holding one word, answering after a set wait.
`timescale 1ns/1ps
module pcim_tgt_model
(
	// Clock and resolved lines.
	input  wire        clock_i,
	input  wire [31:0] ad_i,
	input  wire [3:0]  cbe_n_i,
	input  wire        frame_n_i,
	input  wire        irdy_n_i,
	// Test controls.
	input  wire [3:0]  waits_i,
	input  wire        bad_par_i,
	// Driven lines and observed state.
	output reg  [31:0] ad_o,
	output reg         ad_oe_o,
	output reg         par_o,
	output reg         par_oe_o,
	output reg         trdy_n_o,
	output reg         trdy_oe_o,
	output reg  [31:0] mem_o,
	output reg  [31:0] addr_o,
	output reg  [3:0]  cmd_o
);
	reg [4:0] cnt = 5'h0;
	reg       busy = 1'b0;
	integer   i;
	initial
	begin
		{ad_oe_o, par_oe_o, trdy_oe_o, trdy_n_o, mem_o} = {4'h1, 32'h0};
	end
	// Parity trails its data by one clock; ready is parked high a cycle before floating.
	always @(posedge clock_i)
	begin
		par_oe_o <= ad_oe_o;
		par_o <= ^{ad_i, cbe_n_i} ^ bad_par_i;
		trdy_oe_o <= !trdy_n_o;
		if (!busy && !frame_n_i)
		begin
			{addr_o, cmd_o, busy} <= {ad_i, cbe_n_i, 1'b1};
			cnt <= {1'b0, waits_i} + 5'h1;
		end
		else if (busy && cnt != 5'h0)
			cnt <= cnt - 5'h1;
		else if (busy && trdy_n_o)
			{trdy_n_o, trdy_oe_o, ad_o, ad_oe_o} <= {2'h1, mem_o, !cmd_o[0]};
		else if (busy && !irdy_n_i)
		begin
			{trdy_n_o, ad_oe_o, busy} <= 3'h4;
			for (i = 0; i < 4; i = i + 1)
				if (cmd_o[0] && !cbe_n_i[i]) mem_o[8*i+:8] <= ad_i[8*i+:8];
		end
	end
endmodule // pcim_tgt_model

/* test_pcim_master.sv */
// Self-checking bench for the bus master controller.
`timescale 1ns/1ps
module test_pcim_master;
	reg         clock_i, sys_rst_i, req_valid_i, bad_par, pe;
	reg  [3:0]  req_cmd_i, req_be_n_i, waits;
	reg  [31:0] req_addr_i, req_wdata_i, rd, exp_mem;
	reg  [31:0] cyc = 32'h0;
	integer     err_total = 0, compares = 0;
	wire        req_ready_o, rsp_valid_o, rsp_perr_o, ad_oe_o, cbe_oe_o, par_out_o, par_oe_o;
	wire        frame_n_out_o, frame_n_oe_o, irdy_n_out_o, irdy_n_oe_o, t_ad_oe, t_par, t_par_oe, t_trdy, t_trdy_oe;
	wire        perr_n, perr_oe;
	wire [31:0] rsp_rdata_o, ad_out_o, t_ad, t_mem, t_addr;
	wire [3:0]  cbe_n_out_o, t_cmd;
	// Sustained lines have pull-ups; undriven data lines wander every cycle.
	wire [31:0] ad_w = ad_oe_o ? ad_out_o : t_ad_oe ? t_ad : ~cyc;
	wire [3:0]  cbe_w = cbe_oe_o ? cbe_n_out_o : cyc[3:0];
	wire        par_w = par_oe_o ? par_out_o : t_par_oe ? t_par : cyc[0];
	wire        frame_w = frame_n_oe_o ? frame_n_out_o : 1'b1;
	wire        irdy_w = irdy_n_oe_o ? irdy_n_out_o : 1'b1;
	pcim_master i_pcim_master (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
		.req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_be_n_i(req_be_n_i),
		.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_perr_o(rsp_perr_o),
		.ad_in_i(ad_w), .ad_out_o(ad_out_o), .ad_oe_o(ad_oe_o), .cbe_n_out_o(cbe_n_out_o), .cbe_oe_o(cbe_oe_o),
		.par_in_i(par_w), .par_out_o(par_out_o), .par_oe_o(par_oe_o), .frame_n_out_o(frame_n_out_o),
		.frame_n_oe_o(frame_n_oe_o), .irdy_n_out_o(irdy_n_out_o), .irdy_n_oe_o(irdy_n_oe_o),
		.trdy_n_i(t_trdy_oe ? t_trdy : 1'b1), .perr_n_out_o(perr_n), .perr_n_oe_o(perr_oe),
		.serr_n_out_o(), .serr_n_oe_o(), .frame_n_i(frame_w), .irdy_n_i(irdy_w));
	pcim_tgt_model i_pcim_tgt_model (.clock_i(clock_i), .ad_i(ad_w), .cbe_n_i(cbe_w), .frame_n_i(frame_w),
		.irdy_n_i(irdy_w), .waits_i(waits), .bad_par_i(bad_par), .ad_o(t_ad), .ad_oe_o(t_ad_oe), .par_o(t_par),
		.par_oe_o(t_par_oe), .trdy_n_o(t_trdy), .trdy_oe_o(t_trdy_oe), .mem_o(t_mem), .addr_o(t_addr), .cmd_o(t_cmd));
	task results;
	begin
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] want);
	begin
		compares = compares + 1;
		if (seen !== want)
		begin
			err_total = err_total + 1;
			$display("ERROR %0s expected %h seen %h", nm, want, seen);
		end
	end
	endtask
	// One transfer; waits are bounded so a silent design ends in mismatches, not a hang.
	task xfer(input [3:0] c, input [31:0] a, input [31:0] d, input [3:0] b);
		integer n;
	begin
		{req_valid_i, req_cmd_i, req_addr_i, req_wdata_i, req_be_n_i} = {1'b1, c, a, d, b};
		for (n = 0; n < 40 && req_ready_o !== 1'b1; n = n + 1) @(posedge clock_i) #1;
		chk("request taken", {31'h0, req_ready_o}, 32'h1);
		// Hold the request through the edge that samples the ready pulse.
		@(posedge clock_i) #1;
		req_valid_i = 1'b0;
		for (n = 0; n < 40 && rsp_valid_o !== 1'b1; n = n + 1) @(posedge clock_i) #1;
		chk("answer seen", {31'h0, rsp_valid_o}, 32'h1);
		rd = rsp_rdata_o;
		// The parity verdict follows the answer by one cycle and stands for one cycle.
		@(posedge clock_i) #1;
		pe = rsp_perr_o;
		chk("address", t_addr, c[3:1] == 3'h1 ? a : a & 32'hfffffffc);
		chk("command", {28'h0, t_cmd}, {28'h0, c});
	end
	endtask
	task t_cmds;
		integer k;
		reg [3:0] c;
	begin
		for (k = 0; k < 6; k = k + 1)
		begin
			c = k < 2 ? 4'h2 + k : k < 4 ? 4'h4 + k : 4'h6 + k;
			xfer(c, 32'h00001003 + k * 256, 32'h11223344 + k, 4'h0);
			if (c[0])
				exp_mem = 32'h11223344 + k;
			else
				chk("read data", rd, exp_mem);
			chk("stored word", t_mem, exp_mem);
		end
	end
	endtask
	task t_lanes;
	begin
		xfer(4'h7, 32'h40, 32'h44332211, 4'h0);
		chk("low lane", {24'h0, t_mem[7:0]}, 32'h11);
		xfer(4'h7, 32'h40, 32'hffffffff, 4'hc);
		xfer(4'h6, 32'h40, 32'h0, 4'h0);
		chk("lane merge", rd, 32'h4433ffff);
	end
	endtask
	task t_slow;
	begin
		waits = 4'h9;
		xfer(4'h6, 32'h44, 32'h0, 4'h0);
		waits = 4'h0;
		chk("slow read", rd, 32'h4433ffff);
		chk("clean parity", {31'h0, pe}, 32'h0);
		chk("error line idle", {30'h0, perr_oe, perr_n}, 32'h1);
	end
	endtask
	task t_badpar;
	begin
		bad_par = 1'b1;
		xfer(4'h6, 32'h48, 32'h0, 4'h0);
		bad_par = 1'b0;
		chk("parity error", {31'h0, pe}, 32'h1);
		chk("error line low", {30'h0, perr_oe, perr_n}, 32'h2);
		@(posedge clock_i) #1;
		chk("error line park", {30'h0, perr_oe, perr_n}, 32'h3);
	end
	endtask
	// Free-running clock and the cycle ceiling.
	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
	begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'd3000)
		begin
			err_total = err_total + 1;
			results;
		end
	end
	// Main sequence.
	initial
	begin
		{sys_rst_i, req_valid_i, bad_par, req_cmd_i, req_be_n_i, waits} = {3'h4, 12'hf0};
		{req_addr_i, req_wdata_i, exp_mem} = 96'h0;
		repeat (8) @(posedge clock_i);
		#1;
		sys_rst_i = 1'b0;
		t_cmds;
		t_lanes;
		t_slow;
		t_badpar;
		results;
	end
endmodule // test_pcim_master
